// ---- verilog/esr_top.sv ----
/*
 * error-status register bank of a small programmable controller:
 * gathers program, expansion-bus, output-driver and serial faults
 * into sticky bits, mirrors some as flags, drives the error lamp.
 * assumes event inputs are synchronous one-cycle pulses on aclk,
 * except out_overload which is a level.
 */
`timescale 1ns/100ps
`include "esr_defs.svh"
module esr_top #(
    parameter int MOD_W = 8
) (
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    input  wire logic [`ESR_ADDR_W-1:0]       s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [`ESR_ADDR_W-1:0]       s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    input  wire esr_pkg::esr_prog_events_type prog_ev,
    input  wire logic                         io_timeout,
    input  wire logic                         slave_timeout,
    input  wire logic [MOD_W-1:0]             timeout_module,
    input  wire esr_pkg::esr_mod_access_type  mod_access,
    input  wire logic                         out_overload,
    input  wire logic                         tool_timeout,
    input  wire logic                         ser_parity_err,
    input  wire logic                         ser_frame_err,
    output logic                              error_lamp,
    output logic                              io_timeout_flag,
    output logic                              slave_timeout_flag,
    output logic                              tool_timeout_flag,
    output logic                              parity_flag,
    output logic                              frame_flag,
    output logic                              out_fault_en
);
    localparam int SW = `ESR_STATUS_W;
    localparam int FW = `ESR_STICKY_FLAGS_W;

    logic                   wr_en;
    logic [`ESR_ADDR_W-1:0] wr_addr;
    logic [31:0]            wr_data;
    logic [3:0]             wr_strb;
    logic                   wr_err;
    logic [31:0]            rd_data;
    logic                   rd_err;
    logic [SW-1:0]          status_reg;
    logic [SW-1:0]          status_next;
    logic [SW-1:0]          status_set;
    logic [SW-1:0]          status_clr;
    logic [FW-1:0]          flags_reg;
    logic [FW-1:0]          flags_next;
    logic [FW-1:0]          flags_set;
    logic [FW-1:0]          flags_clr;
    logic                   out_en_reg;
    logic [MOD_W-1:0]       module_reg;
    logic                   absent_access;
    logic                   slave_tmo_any;
    logic                   status_wr_hit;
    logic [31:0]            status_wr;
    logic [31:0]            flags_wr;

    // ==========================================================
    // helpers
    // merge written lanes into the current word
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0]  strb
    );
        logic [31:0] mask;
        mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old_val & ~mask) | (new_val & mask);
    endfunction

    function automatic logic hit(
        input logic [`ESR_ADDR_W-1:0] addr,
        input logic [`ESR_ADDR_W-1:0] ofs
    );
        return addr == ofs;
    endfunction

    // ==========================================================
    // bus slave
    esr_axil_slave #(
        .AW (`ESR_ADDR_W)
    ) u_bus (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (s_axi_awaddr),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .bresp   (s_axi_bresp),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .araddr  (s_axi_araddr),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_err  (wr_err),
        .rd_data (rd_data),
        .rd_err  (rd_err)
    );

    assign wr_err = !(hit(wr_addr, `ESR_OFS_STATUS) ||
                      hit(wr_addr, `ESR_OFS_MODULE) ||
                      hit(wr_addr, `ESR_OFS_FLAGS));

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        if (hit(s_axi_araddr, `ESR_OFS_STATUS)) begin
            rd_data[SW-1:0] = status_reg;
        end else if (hit(s_axi_araddr, `ESR_OFS_MODULE)) begin
            rd_data[MOD_W-1:0] = module_reg;
        end else if (hit(s_axi_araddr, `ESR_OFS_FLAGS)) begin
            rd_data[`ESR_FLAG_IO_TMO]  = status_reg[`ESR_BIT_IO_TMO];
            rd_data[`ESR_FLAG_SLV_TMO] = status_reg[`ESR_BIT_SLV_TMO];
            rd_data[`ESR_FLAG_FRAME:`ESR_FLAG_TOOL_TMO] = flags_reg;
            rd_data[`ESR_FLAG_OUT_EN]  = out_en_reg;
        end else begin
            rd_err = 1'b1;
        end
    end

    // ==========================================================
    // error sources
    // absent module, including the plain-module window, is a timeout
    assign absent_access = mod_access.valid & ~mod_access.present;
    assign slave_tmo_any = slave_timeout | absent_access;

    always_comb begin
        status_set = '0;
        status_set[`ESR_BIT_NO_PROG]    = prog_ev.no_prog;
        status_set[`ESR_BIT_IO_TMO]     = io_timeout;
        status_set[`ESR_BIT_SLV_TMO]    = slave_tmo_any;
        status_set[`ESR_BIT_OPCODE]     = prog_ev.opcode_bad;
        status_set[`ESR_BIT_ARITH]      = prog_ev.arith_bad;
        status_set[`ESR_BIT_LABEL_DUP]  = prog_ev.label_dup;
        status_set[`ESR_BIT_SYNTAX]     = prog_ev.syntax_bad;
        status_set[`ESR_BIT_LABEL_MISS] = prog_ev.label_miss;
        // overload is only reported while software enables it
        status_set[`ESR_BIT_OVERLOAD]   = out_overload & out_en_reg;
    end

    // status write: every bit written as zero is cleared
    assign status_wr  = lane_merge({16'h0000, status_reg}, wr_data, wr_strb);
    // one decode of a status write, shared by the clear and the sticky-hold and lamp-clear checks
    assign status_wr_hit = wr_en & hit(wr_addr, `ESR_OFS_STATUS);
    assign status_clr    = status_wr_hit ? ~status_wr[SW-1:0] : '0;

    esr_sticky #(
        .WIDTH   (SW),
        .RST_VAL (`ESR_RST_STATUS)
    ) u_status (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .set_mask (status_set),
        .clr_mask (status_clr),
        .q_reg    (status_reg),
        .q_next   (status_next)
    );

    // ==========================================================
    // companion flags: write one to clear the sticky ones
    assign flags_set = {ser_frame_err, ser_parity_err, tool_timeout};
    assign flags_wr  = lane_merge(32'h0000_0000, wr_data, wr_strb);
    assign flags_clr = (wr_en && hit(wr_addr, `ESR_OFS_FLAGS)) ?
                       flags_wr[`ESR_FLAG_FRAME:`ESR_FLAG_TOOL_TMO] : '0;

    esr_sticky #(
        .WIDTH   (FW),
        .RST_VAL (`ESR_RST_FLAGS)
    ) u_flags (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .set_mask (flags_set),
        .clr_mask (flags_clr),
        .q_reg    (flags_reg),
        .q_next   (flags_next)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_en_reg <= 1'b0;
        end else if (wr_en && hit(wr_addr, `ESR_OFS_FLAGS) && wr_strb[1]) begin
            out_en_reg <= wr_data[`ESR_FLAG_OUT_EN];
        end
    end

    // io and slave timeouts both load the same timeout_module; an absent-module access records no number
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            module_reg <= '0;
        end else if (io_timeout || slave_timeout) begin
            module_reg <= timeout_module;
        end
    end

    // ==========================================================
    // outputs, each from its own flip-flop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            error_lamp         <= 1'b0;
            io_timeout_flag    <= 1'b0;
            slave_timeout_flag <= 1'b0;
            tool_timeout_flag  <= 1'b0;
            parity_flag        <= 1'b0;
            frame_flag         <= 1'b0;
            out_fault_en       <= 1'b0;
        end else begin
            // lamp tracks the register in the same cycle
            error_lamp         <= |status_next;
            io_timeout_flag    <= status_next[`ESR_BIT_IO_TMO];
            slave_timeout_flag <= status_next[`ESR_BIT_SLV_TMO];
            tool_timeout_flag  <= flags_next[0];
            parity_flag        <= flags_next[1];
            frame_flag         <= flags_next[2];
            out_fault_en       <= out_en_reg;
        end
    end

    // ==========================================================
    // checks
    a_no_prog_set: assert property (
        @(posedge aclk) disable iff (!aresetn)
        prog_ev.no_prog |=> status_reg[`ESR_BIT_NO_PROG])
        else $error("missing program did not set its bit");

    a_io_flag_mirror: assert property (
        @(posedge aclk) disable iff (!aresetn)
        io_timeout |=> status_reg[`ESR_BIT_IO_TMO] ##1 io_timeout_flag)
        else $error("io timeout bit or flag not raised");

    a_slv_flag_mirror: assert property (
        @(posedge aclk) disable iff (!aresetn)
        slave_timeout |=> status_reg[`ESR_BIT_SLV_TMO] ##1 slave_timeout_flag)
        else $error("slave timeout bit or flag not raised");

    a_absent_access: assert property (
        @(posedge aclk) disable iff (!aresetn)
        mod_access.valid && !mod_access.present
        |=> status_reg[`ESR_BIT_SLV_TMO])
        else $error("absent module access not reported");

    a_prog_faults: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (prog_ev.opcode_bad || prog_ev.arith_bad || prog_ev.label_miss)
        |=> |(status_reg & 16'h0460))
        else $error("program fault bit not raised");

    a_syntax_bits: assert property (
        @(posedge aclk) disable iff (!aresetn)
        prog_ev.label_dup && !prog_ev.syntax_bad
        |=> status_reg[`ESR_BIT_LABEL_DUP])
        else $error("duplicate label bit not raised");

    a_overload_gate: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $rose(status_reg[`ESR_BIT_OVERLOAD])
        |-> $past(out_overload) && $past(out_en_reg))
        else $error("overload reported while disabled");

    a_serial_flags: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ser_parity_err |=> ##1 parity_flag)
        else $error("parity flag not raised");

    a_lamp_follows: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ##1 error_lamp == (status_reg != 16'h0000))
        else $error("error lamp disagrees with status");

    a_zero_clears: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_en && hit(wr_addr, `ESR_OFS_STATUS) && wr_strb == 4'hF &&
        wr_data == 32'h0000_0000 && status_set == '0
        |=> status_reg == 16'h0000)
        else $error("writing zero did not clear status");

    a_module_num: assert property (
        @(posedge aclk) disable iff (!aresetn)
        io_timeout |=> module_reg == $past(timeout_module))
        else $error("failing module number not recorded");

    a_sticky_hold: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $fell(status_reg[`ESR_BIT_IO_TMO])
        |-> $past(status_wr_hit))
        else $error("status bit dropped without a write");

    // single-event checks for syntax, overload, tool, frame and slave module number, plus lamp set and clear, tighter than the grouped ones
    a_syntax_bit: assert property (
        @(posedge aclk) disable iff (!aresetn)
        prog_ev.syntax_bad |=> status_reg[`ESR_BIT_SYNTAX])
        else $error("syntax bit not raised");

    a_overload_set: assert property (
        @(posedge aclk) disable iff (!aresetn)
        out_overload && out_en_reg |=> status_reg[`ESR_BIT_OVERLOAD])
        else $error("enabled overload not reported");

    a_tool_flag: assert property (
        @(posedge aclk) disable iff (!aresetn)
        tool_timeout |=> tool_timeout_flag)
        else $error("tool timeout flag not raised");

    a_frame_flag: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ser_frame_err |=> frame_flag)
        else $error("frame flag not raised");

    a_lamp_set: assert property (
        @(posedge aclk) disable iff (!aresetn)
        status_set != 16'h0000 |=> error_lamp)
        else $error("error lamp not lit on a new error");

    a_lamp_clear: assert property (
        @(posedge aclk) disable iff (!aresetn)
        status_wr_hit && wr_strb == 4'hF && wr_data == 32'h0000_0000 &&
        status_set == 16'h0000 |=> !error_lamp)
        else $error("error lamp lit after clearing");

    a_slv_module_num: assert property (
        @(posedge aclk) disable iff (!aresetn)
        slave_timeout |=> module_reg == $past(timeout_module))
        else $error("slave module number not recorded");
endmodule

// ---- include/esr_defs.svh ----
/*
 * constants of the error-status register bank: byte offsets, field
 * positions and reset values, shared by the top level, the bus slave and the bench.
 * assumes it is included by its bare name before any module using it.
 */
//
// Behaviour
// - status bit 2 set when program missing/invalid
// - io timeout sets bit 3 and its flag
// - slave timeout sets bit 4 and its flag
// - access to absent module raises slave timeout
// - illegal fetched opcode sets bit 5
// - bad arithmetic specification sets bit 6
// - duplicate label bit 7, other syntax bit 8
// - jump to missing label sets bit 10
// - overload sets bit 9 only when enabled
// - tool-initiated slave timeout sets its flag
// - serial parity error sets its flag
// - serial framing error sets its flag
// - error lamp lit while status nonzero
// - timeout records failing module number (io and slave timeout inputs only; an absent-module access records none)
`ifndef ESR_DEFS_SVH
`define ESR_DEFS_SVH

// ==========================================================
// register byte offsets
`define ESR_OFS_STATUS      12'h7D8
`define ESR_OFS_MODULE      12'h7DC
`define ESR_OFS_FLAGS       12'h800
`define ESR_ADDR_W          12

// ==========================================================
// status register fields
`define ESR_STATUS_W        16
`define ESR_BIT_NO_PROG     2
`define ESR_BIT_IO_TMO      3
`define ESR_BIT_SLV_TMO     4
`define ESR_BIT_OPCODE      5
`define ESR_BIT_ARITH       6
`define ESR_BIT_LABEL_DUP   7
`define ESR_BIT_SYNTAX      8
`define ESR_BIT_OVERLOAD    9
`define ESR_BIT_LABEL_MISS  10

// ==========================================================
// flags register fields
`define ESR_FLAG_IO_TMO     0
`define ESR_FLAG_SLV_TMO    1
`define ESR_FLAG_TOOL_TMO   2
`define ESR_FLAG_PARITY     3
`define ESR_FLAG_FRAME      4
`define ESR_FLAG_OUT_EN     8
`define ESR_STICKY_FLAGS_W  3

// ==========================================================
// reset values and bus answers
`define ESR_RST_STATUS      16'h0000
`define ESR_RST_FLAGS       3'h0
`define ESR_RESP_OKAY       2'h0
`define ESR_RESP_SLVERR     2'h2
`define ESR_MOD_RANGE_LO    16'h0BB8
`define ESR_MOD_RANGE_HI    16'h0C4D

`endif

// ---- include/esr_pkg.sv ----
/*
 * types of the error-status register bank.
 * assumes esr_defs.svh is compiled alongside.
 */
package esr_pkg;

    // ==========================================================
    // one-cycle fault events from the program interpreter
    typedef struct packed {
        logic no_prog;
        logic opcode_bad;
        logic arith_bad;
        logic label_dup;
        logic syntax_bad;
        logic label_miss;
    } esr_prog_events_type;

    // ==========================================================
    // one module access on the expansion bus
    typedef struct packed {
        logic        valid;
        logic        present;
        logic [15:0] reg_num;
    } esr_mod_access_type;

endpackage

// ---- verilog/esr_sticky.sv ----
/*
 * sticky flag array: hardware sets, software clears, set wins.
 * assumes set and clear are synchronous one-cycle masks.
 */
`timescale 1ns/100ps
module esr_sticky #(
    parameter int             WIDTH    = 16,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] set_mask,
    input  wire logic [WIDTH-1:0] clr_mask,
    output logic      [WIDTH-1:0] q_reg,
    output logic      [WIDTH-1:0] q_next
);
    // a set arriving with a clear is kept, so no event is lost
    always_comb begin
        q_next = (q_reg & ~clr_mask) | set_mask;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_reg <= RST_VAL;
        end else begin
            q_reg <= q_next;
        end
    end
endmodule

// ---- verilog/esr_axil_slave.sv ----
/*
 * minimal AXI4-Lite slave: one write and one read at a time.
 * assumes the parent decodes addresses combinationally and
 * supplies read data and error answers in the same cycle.
 */
`timescale 1ns/100ps
`include "esr_defs.svh"
module esr_axil_slave #(
    parameter int AW = 12
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [AW-1:0] awaddr,
    input  wire logic          awvalid,
    output logic               awready,
    input  wire logic [31:0]   wdata,
    input  wire logic [3:0]    wstrb,
    input  wire logic          wvalid,
    output logic               wready,
    output logic [1:0]         bresp,
    output logic               bvalid,
    input  wire logic          bready,
    input  wire logic [AW-1:0] araddr,
    input  wire logic          arvalid,
    output logic               arready,
    output logic [31:0]        rdata,
    output logic [1:0]         rresp,
    output logic               rvalid,
    input  wire logic          rready,
    output logic               wr_en,
    output logic [AW-1:0]      wr_addr,
    output logic [31:0]        wr_data,
    output logic [3:0]         wr_strb,
    input  wire logic          wr_err,
    input  wire logic [31:0]   rd_data,
    input  wire logic          rd_err
);
    logic aw_got_reg;
    logic w_got_reg;

    // ==========================================================
    // write path: address and data taken in either order
    assign wr_en = aw_got_reg & w_got_reg & ~bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg <= 1'b0;
            awready    <= 1'b1;
            wr_addr    <= '0;
        end else if (awvalid && awready) begin
            aw_got_reg <= 1'b1;
            awready    <= 1'b0;
            wr_addr    <= awaddr;
        end else if (wr_en) begin
            aw_got_reg <= 1'b0;
        end else if (bvalid && bready) begin
            awready    <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_reg <= 1'b0;
            wready    <= 1'b1;
            wr_data   <= 32'h0000_0000;
            wr_strb   <= 4'h0;
        end else if (wvalid && wready) begin
            w_got_reg <= 1'b1;
            wready    <= 1'b0;
            wr_data   <= wdata;
            wr_strb   <= wstrb;
        end else if (wr_en) begin
            w_got_reg <= 1'b0;
        end else if (bvalid && bready) begin
            wready    <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= `ESR_RESP_OKAY;
        end else if (wr_en) begin
            bvalid <= 1'b1;
            bresp  <= wr_err ? `ESR_RESP_SLVERR : `ESR_RESP_OKAY;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // read path: data captured at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `ESR_RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_data;
            rresp   <= rd_err ? `ESR_RESP_SLVERR : `ESR_RESP_OKAY;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
        end
    end
endmodule

// ---- sim/esr_bus_model.sv ----
/*
 * model of the expansion bus modules: a fitted module answers,
 * a missing one times out after a delay.
 * assumes one request pulse at a time, synchronous to aclk.
 */
`timescale 1ns/100ps
module esr_bus_model #(
    parameter int WAIT_CYC = 4
) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic                   req,
    input  wire logic [1:0]             kind,
    input  wire logic                   fitted,
    input  wire logic [7:0]             mod_num,
    input  wire logic [15:0]            reg_num,
    output logic                        io_timeout,
    output logic                        slave_timeout,
    output logic [7:0]                  timeout_module,
    output esr_pkg::esr_mod_access_type mod_access
);
    int cnt;
    // ==========================================================
    // number lines toggle when unqualified, so stale values show
    always @(posedge aclk) begin
        io_timeout <= 1'b0;
        slave_timeout <= 1'b0;
        timeout_module <= ~timeout_module;
        mod_access <= '{1'b0, 1'b0, ~mod_access.reg_num};
        cnt <= (cnt > 0) ? cnt - 1 : 0;
        if (req) begin
            cnt <= WAIT_CYC;
        end
        if (cnt == 1) begin
            timeout_module <= mod_num;
            io_timeout <= !fitted && kind == 2'h0;
            slave_timeout <= !fitted && kind == 2'h1;
            mod_access <= '{kind == 2'h2, fitted, reg_num};
        end
        if (!aresetn) begin
            cnt <= 0;
            timeout_module <= 8'h00;
            mod_access <= '0;
        end
    end
endmodule

// ---- sim/tb_plc_error_status_register.sv ----
/*
 * self-checking bench of the error-status register bank.
 * assumes esr_defs.svh and esr_pkg are compiled first.
 */
`timescale 1ns/100ps
`include "esr_defs.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
    $display("CHECK FAILED at %0t: value mismatch", $time); end end
module tb_plc_error_status_register;
    logic aclk = 0, aresetn = 0, req = 0, fitted = 0, out_overload = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, tool_timeout = 0;
    logic ser_parity_err = 0, ser_frame_err = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] kind = 0, s_axi_bresp, s_axi_rresp, rsp;
    logic [7:0] mod_num = 0, timeout_module;
    logic [15:0] reg_num = 0;
    logic [31:0] seed = 32'h00005127;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, error_lamp, io_timeout, slave_timeout, out_fault_en;
    logic io_timeout_flag, slave_timeout_flag, tool_timeout_flag;
    logic parity_flag, frame_flag;
    esr_pkg::esr_prog_events_type prog_ev = '0;
    esr_pkg::esr_mod_access_type mod_access;
    int err_total = 0, n_compared = 0;
    esr_top i_dut (.*);
    esr_bus_model i_bus (.*);
    initial forever #5 aclk = ~aclk;
    // ==========================================================
    // bench helpers
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int ev_bit(input int i);
        int t[6] = '{10, 8, 7, 6, 5, 2};
        return t[i];
    endfunction
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1;
        s_axi_awvalid <= 1; s_axi_wvalid <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 0;
    endtask
    task automatic rdr(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata; rsp = s_axi_rresp;
        s_axi_rready <= 0;
    endtask
    task automatic bus(input logic [1:0] k, input logic f);
        @(posedge aclk);
        kind <= k; fitted <= f; mod_num <= 8'(xs()); req <= 1;
        reg_num <= 16'(3000 + xs() % 150);
        @(posedge aclk);
        req <= 0;
        repeat (8) @(posedge aclk);
    endtask
    task automatic end_of_test();
        $display("compared %0d, errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        end_of_test();
    end
    // ==========================================================
    // scenarios
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        rdr(`ESR_OFS_STATUS); `CHK({rd, error_lamp}, 33'h0)
        for (int i = 0; i < 6; i++) begin
            @(posedge aclk);
            prog_ev <= esr_pkg::esr_prog_events_type'(6'h01 << i);
            @(posedge aclk);
            prog_ev <= '0;
            repeat (2) @(posedge aclk);
            #1 `CHK(error_lamp, 1'b1)
            rdr(`ESR_OFS_STATUS); `CHK(rd, 32'h1 << ev_bit(i))
            wr(`ESR_OFS_STATUS, 0); rdr(`ESR_OFS_STATUS);
            `CHK({rd, error_lamp}, 33'h0)
        end
        for (int k = 0; k < 3; k++) begin
            bus(2'(k), 1); rdr(`ESR_OFS_STATUS); `CHK(rd, 32'h0)
            bus(2'(k), 0); rdr(`ESR_OFS_STATUS);
            `CHK(rd, k == 0 ? 32'h8 : 32'h10)
            `CHK({slave_timeout_flag, io_timeout_flag}, k ? 2'h2 : 2'h1)
            if (k < 2) begin
                rdr(`ESR_OFS_MODULE); `CHK(rd[7:0], mod_num)
            end
            wr(`ESR_OFS_STATUS, 0);
        end
        for (int i = 0; i < 3; i++) begin
            @(posedge aclk);
            {ser_frame_err, ser_parity_err, tool_timeout} <= 3'h1 << i;
            @(posedge aclk);
            {ser_frame_err, ser_parity_err, tool_timeout} <= 3'h0;
            rdr(`ESR_OFS_FLAGS); `CHK(rd, 32'h4 << i)
            `CHK({frame_flag, parity_flag, tool_timeout_flag}, 3'h1 << i)
            wr(`ESR_OFS_FLAGS, 32'h4 << i);
        end
        @(posedge aclk);
        out_overload <= 1;
        rdr(`ESR_OFS_STATUS); `CHK(rd, 32'h0)
        wr(`ESR_OFS_FLAGS, 32'h100); rdr(`ESR_OFS_STATUS);
        `CHK({rd, out_fault_en}, {32'h200, 1'b1})
        @(posedge aclk);
        out_overload <= 0;
        rdr(`ESR_OFS_STATUS); `CHK(rd, 32'h200)
        wr(`ESR_OFS_STATUS, 0); `CHK(rsp, 2'h0)
        rdr(`ESR_OFS_STATUS); `CHK(rd, 32'h0)
        rdr(12'h004); `CHK({rsp, rd}, {2'h2, 32'h0})
        wr(12'h004, 32'h0); `CHK(rsp, 2'h2)
        end_of_test();
    end
endmodule
